// ===== rtl/rdlc_pkg.sv
// Constants, field layouts and carrier types for the ring detector and
// line configuration block.
// Assumes a single 125 MHz core clock and an APB master on the host side.

package rdlc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_HOOK    = 8'h35;
   localparam logic [7:0] IDX_RATE    = 8'h37;
   localparam logic [7:0] IDX_LINE    = 8'h40;
   localparam logic [7:0] IDX_RMODE   = 8'h42;
   localparam logic [7:0] IDX_RMIN    = 8'h46;
   localparam logic [7:0] IDX_RQUAL   = 8'h47;
   localparam logic [7:0] IDX_RMAX    = 8'h48;
   localparam logic [7:0] IDX_HYB0    = 8'h5D;
   localparam logic [7:0] IDX_HYB7    = 8'h64;
   localparam logic [7:0] IDX_ACIMP   = 8'h70;
   localparam logic [7:0] IDX_RSTAT   = 8'h71;

   localparam int         HYB_NUM     = 8;

   // Reset values
   localparam logic [1:0] DCT_RESET   = 2'h2;
   localparam logic [3:0] RATE_RESET  = 4'h0;

   // Dc termination codes
   localparam logic [1:0] DCT_LOWV    = 2'h0;
   localparam logic [1:0] DCT_JAPAN   = 2'h1;
   localparam logic [1:0] DCT_NA      = 2'h2;
   localparam logic [1:0] DCT_LIMIT   = 2'h3;

   // Thresholds in ring sense codes of 0.1 V each
   localparam logic signed [12:0] THR_15V0 = 13'sh0096;
   localparam logic signed [12:0] THR_21V5 = 13'sh00D7;

   // Sample rates in Hz, selected by sample_rate_sel
   localparam logic [9:0][15:0] RATE_TABLE = {
      16'h3E80, 16'h3592, 16'h2EE0, 16'h282E, 16'h2580,
      16'h2328, 16'h20D0, 16'h2025, 16'h1C20, 16'h1F40};
   localparam logic [3:0] RATE_NUM    = 4'hA;

   // One-shot length in sample periods
   localparam int         ONESHOT_SAMPLES = 65536;

   // Validation time units, in sample periods per field step
   localparam logic [15:0] INT_UNIT   = 16'h0010;
   localparam logic [15:0] QUAL_UNIT  = 16'h0400;
   localparam logic [15:0] END_UNIT   = 16'h0400;
   localparam logic [15:0] DLY_UNIT   = 16'h0800;

   // Validation states, Gray coded along idle, qualify, delay, ringing
   typedef enum logic [1:0] {
      RDLC_IDLE  = 2'b00,
      RDLC_QUAL  = 2'b01,
      RDLC_DELAY = 2'b11,
      RDLC_RING  = 2'b10
   } rdlc_vstate_t;

   typedef enum logic [1:0] {
      RDLC_POL_NONE = 2'b00,
      RDLC_POL_POS  = 2'b01,
      RDLC_POL_NEG  = 2'b10
   } rdlc_pol_t;

   // Line configuration presented to the analog front end
   typedef struct packed {
      logic [1:0]             dc_term_mode;
      logic [1:0]             ac_imp_sel;
      logic                   ring_thresh_sel;
      logic                   ringer_imp_synth_en;
      logic                   hook_ctrl;
      logic [HYB_NUM*8-1:0]   hybrid_coef;
   } rdlc_line_cfg_t;

   // Ring detector status outputs
   typedef struct packed {
      logic                   ring_pos_flag;
      logic                   ring_neg_flag;
      logic                   ring_oneshot_flag;
      logic                   ring_valid;
      logic                   ring_active;
   } rdlc_ring_stat_t;

endpackage

// ===== rtl/rdlc_top.sv
// Ring detection, ring validation and line termination configuration.
// Assumes an APB master on core_clk_i and ring sense samples that are
// synchronous to the same clock, in signed codes of 0.1 V.
//
// Implementation choices: the register addresses and the APB register port.

`timescale 1ns/1ps
`default_nettype none

module rdlc_top #(
   parameter int CLK_HZ      = 125_000_000,
   parameter int ONESHOT_LEN = rdlc_pkg::ONESHOT_SAMPLES
) (
   input  wire logic                     core_clk_i,
   input  wire logic                     reset_n_i,
   input  wire logic                     psel_i,
   input  wire logic                     penable_i,
   input  wire logic                     pwrite_i,
   input  wire logic [11:0]              paddr_i,
   input  wire logic [31:0]              pwdata_i,
   output logic      [31:0]              prdata_o,
   output logic                          pready_o,
   output logic                          pslverr_o,
   input  wire logic signed [11:0]       ring_sense_p_i,
   input  wire logic signed [11:0]       ring_sense_n_i,
   output rdlc_pkg::rdlc_line_cfg_t      line_cfg_o,
   output rdlc_pkg::rdlc_ring_stat_t     ring_stat_o,
   output logic                          sample_tick_o
);
   import rdlc_pkg::*;

   // ******************************************************************
   // State
   // ******************************************************************
   typedef struct packed {
      // Configuration
      logic                hook;
      logic [3:0]          rate_sel;
      logic                thr_sel;
      logic                rz;
      logic [1:0]          dct;
      logic                fw;
      logic [5:0]          min_int;
      logic [1:0]          dly_hi;
      logic [2:0]          qual;
      logic [3:0]          rto;
      logic                dly_lo;
      logic [5:0]          max_int;
      logic                ring_validate_en;
      logic [1:0]          act;
      logic [HYB_NUM-1:0][7:0] hyb;
      // Sample timebase
      logic [15:0]         div_cnt;
      logic                tick;
      // Detector
      logic                pos;
      logic                neg;
      rdlc_pol_t           last_pol;
      logic [16:0]         os_cnt;
      logic                os_flag;
      logic                hook_d;
      // Validation
      rdlc_vstate_t        vstate;
      logic [15:0]         int_cnt;
      logic [15:0]         dur_cnt;
      logic [15:0]         end_cnt;
      logic [15:0]         dly_cnt;
      logic                valid;
      logic                active;
      // Bus
      logic                pready;
      logic                pslverr;
      logic [31:0]         prdata;
   } rdlc_state_t;

   rdlc_state_t r;
   rdlc_state_t next_r;

   // ******************************************************************
   // Functions
   // ******************************************************************

   // Register hit test, shared by read and write paths
   function automatic logic is_mapped(input logic [7:0] idx);
      logic hit;
      hit = 1'b0;
      case (idx)
         IDX_HOOK, IDX_RATE, IDX_LINE, IDX_RMODE,
         IDX_RMIN, IDX_RQUAL, IDX_RMAX,
         IDX_ACIMP, IDX_RSTAT: begin
            hit = 1'b1;
         end
         default: begin
            hit = (idx >= IDX_HYB0) && (idx <= IDX_HYB7);
         end
      endcase
      return hit;
   endfunction

   // Clock cycles per sample for a rate code; unknown codes use entry 0
   function automatic logic [15:0] rate_div(input logic [3:0] sel);
      logic [15:0] hz;
      hz = (sel < RATE_NUM) ? RATE_TABLE[sel] : RATE_TABLE[0];
      return 16'(CLK_HZ / int'(hz));
   endfunction

   // ******************************************************************
   // Combinational next state
   // ******************************************************************
   logic                   apb_done;
   logic [7:0]             idx;
   logic                   aligned;
   logic                   hit;
   logic [7:0]             wd;
   logic signed [12:0]     diff;
   logic signed [12:0]     thr;
   logic                   pos_n;
   logic                   neg_n;
   logic                   trig;
   logic                   crossing;
   logic                   offhook_evt;
   logic                   set_valid;
   logic [15:0]            min_lim;
   logic [15:0]            max_lim;
   logic [15:0]            qual_lim;
   logic [15:0]            end_lim;
   logic [15:0]            dly_lim;
   logic [15:0]            end_nxt;

   always_comb begin
      next_r = r;

      idx      = paddr_i[9:2];
      aligned  = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0);
      hit      = aligned && is_mapped(idx);
      wd       = pwdata_i[7:0];
      apb_done = psel_i && penable_i && r.pready;

      // ***************************************************************
      // Sample timebase
      // ***************************************************************
      // Rate change takes effect at the next sample boundary
      next_r.tick = 1'b0;
      if (r.div_cnt == 16'h0000) begin
         next_r.div_cnt = rate_div(r.rate_sel) - 16'h0001;
         next_r.tick    = 1'b1;
      end else begin
         next_r.div_cnt = r.div_cnt - 16'h0001;
      end

      // ***************************************************************
      // Threshold detector
      // ***************************************************************
      diff  = 13'(ring_sense_p_i) - 13'(ring_sense_n_i);
      thr   = r.thr_sel ? THR_21V5 : THR_15V0;
      pos_n = diff > thr;
      neg_n = diff < -thr;
      trig  = pos_n || (r.fw && neg_n);
      crossing = (pos_n && r.last_pol == RDLC_POL_NEG) ||
                 (neg_n && r.last_pol == RDLC_POL_POS);
      offhook_evt = r.hook && !r.hook_d;
      next_r.hook_d = r.hook;

      // ***************************************************************
      // Ring one-shot
      // ***************************************************************
      // Off-hook clears first; a ring in the same tick still retriggers
      if (offhook_evt) begin
         next_r.os_cnt  = 17'h00000;
         next_r.os_flag = 1'b0;
      end
      if (r.tick) begin
         next_r.pos = pos_n;
         next_r.neg = neg_n;
         if (pos_n) begin
            next_r.last_pol = RDLC_POL_POS;
         end else if (neg_n) begin
            next_r.last_pol = RDLC_POL_NEG;
         end
         if (trig) begin
            next_r.os_cnt  = 17'(ONESHOT_LEN);
            next_r.os_flag = 1'b1;
         end else if (!offhook_evt && r.os_cnt != 17'h00000) begin
            next_r.os_cnt  = r.os_cnt - 17'h00001;
            next_r.os_flag = (r.os_cnt != 17'h00001);
         end
      end

      // ***************************************************************
      // Ring validation
      // ***************************************************************
      min_lim  = 16'(r.min_int) * INT_UNIT;
      max_lim  = 16'(r.max_int) * INT_UNIT;
      qual_lim = 16'({1'b0, r.qual} + 4'h1) * QUAL_UNIT;
      end_lim  = 16'({1'b0, r.rto} + 5'h01) * END_UNIT;
      dly_lim  = 16'({r.dly_hi, r.dly_lo}) * DLY_UNIT;
      end_nxt  = crossing ? 16'h0000 : r.end_cnt + 16'h0001;
      set_valid = 1'b0;

      if (r.tick) begin
         if (crossing) begin
            next_r.int_cnt = 16'h0000;
         end else if (r.int_cnt != 16'hFFFF) begin
            next_r.int_cnt = r.int_cnt + 16'h0001;
         end
         case (r.vstate)
            RDLC_IDLE: begin
               if (crossing) begin
                  next_r.vstate  = RDLC_QUAL;
                  next_r.dur_cnt = 16'h0000;
               end
            end
            RDLC_QUAL: begin
               next_r.dur_cnt = r.dur_cnt + 16'h0001;
               if (crossing && r.int_cnt < min_lim) begin
                  next_r.vstate = RDLC_IDLE;
               end else if (r.int_cnt > max_lim) begin
                  next_r.vstate = RDLC_IDLE;
               end else if (r.dur_cnt >= qual_lim) begin
                  next_r.vstate  = RDLC_DELAY;
                  next_r.dly_cnt = 16'h0000;
                  next_r.end_cnt = 16'h0000;
               end
            end
            RDLC_DELAY: begin
               // Frequency is no longer checked once qualified
               next_r.dly_cnt = r.dly_cnt + 16'h0001;
               next_r.end_cnt = end_nxt;
               if (end_nxt >= end_lim) begin
                  next_r.vstate = RDLC_IDLE;
               end else if (r.dly_cnt >= dly_lim) begin
                  next_r.vstate = RDLC_RING;
                  set_valid     = 1'b1;
               end
            end
            RDLC_RING: begin
               next_r.end_cnt = end_nxt;
               if (end_nxt >= end_lim) begin
                  next_r.vstate = RDLC_IDLE;
               end
            end
            default: begin
               next_r.vstate = RDLC_IDLE;
            end
         endcase
      end
      if (!r.ring_validate_en) begin
         next_r.vstate = RDLC_IDLE;
      end
      next_r.active = (next_r.vstate == RDLC_RING);

      // ***************************************************************
      // APB slave
      // ***************************************************************
      // One wait state: pready rises on the second access cycle
      next_r.pready  = psel_i && penable_i && !r.pready;
      next_r.pslverr = psel_i && penable_i && !r.pready && !hit;
      if (psel_i && penable_i && !r.pready) begin
         next_r.prdata = 32'h00000000;
         if (!pwrite_i && hit) begin
            case (idx)
               IDX_HOOK: begin
                  next_r.prdata[0] = r.hook;
                  next_r.prdata[2] = r.os_flag;
                  next_r.prdata[5] = r.neg;
                  next_r.prdata[6] = r.pos;
               end
               IDX_RATE: begin
                  next_r.prdata[3:0] = r.rate_sel;
               end
               IDX_LINE: begin
                  next_r.prdata[3:0] = {r.dct, r.rz, r.thr_sel};
               end
               IDX_RMODE: begin
                  next_r.prdata[1] = r.fw;
               end
               IDX_RMIN: begin
                  next_r.prdata[7:0] = {r.dly_hi, r.min_int};
               end
               IDX_RQUAL: begin
                  next_r.prdata[7:0] = {r.dly_lo, r.rto, r.qual};
               end
               IDX_RMAX: begin
                  next_r.prdata[7:0] = {r.ring_validate_en, 1'b0, r.max_int};
               end
               IDX_ACIMP: begin
                  next_r.prdata[1:0] = r.act;
               end
               IDX_RSTAT: begin
                  next_r.prdata[1:0] = {r.active, r.valid};
               end
               default: begin
                  next_r.prdata[7:0] = r.hyb[3'(idx - IDX_HYB0)];
               end
            endcase
         end
      end

      if (apb_done && pwrite_i && hit) begin
         case (idx)
            IDX_HOOK: begin
               next_r.hook = wd[0];
            end
            IDX_RATE: begin
               next_r.rate_sel = wd[3:0];
            end
            IDX_LINE: begin
               next_r.thr_sel = wd[0];
               next_r.rz      = wd[1];
               next_r.dct     = wd[3:2];
            end
            IDX_RMODE: begin
               next_r.fw = wd[1];
            end
            IDX_RMIN: begin
               next_r.min_int = wd[5:0];
               next_r.dly_hi  = wd[7:6];
            end
            IDX_RQUAL: begin
               next_r.qual   = wd[2:0];
               next_r.rto    = wd[6:3];
               next_r.dly_lo = wd[7];
            end
            IDX_RMAX: begin
               next_r.max_int = wd[5:0];
               next_r.ring_validate_en    = wd[7];
            end
            IDX_ACIMP: begin
               next_r.act = wd[1:0];
            end
            IDX_RSTAT: begin
               if (wd[0]) begin
                  next_r.valid = 1'b0;
               end
            end
            default: begin
               next_r.hyb[3'(idx - IDX_HYB0)] = wd;
            end
         endcase
      end

      // A new valid ring outranks a clear in the same cycle
      if (set_valid) begin
         next_r.valid = 1'b1;
      end
   end

   // ******************************************************************
   // Registers
   // ******************************************************************
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         r          <= '0;
         r.dct      <= DCT_RESET;
         r.rate_sel <= RATE_RESET;
         r.fw       <= 1'b0;
         r.vstate   <= RDLC_IDLE;
         r.last_pol <= RDLC_POL_NONE;
      end else begin
         r <= next_r;
      end
   end

   // ******************************************************************
   // Outputs
   // ******************************************************************
   // Dc codes: 10 North American, 11 current limit, 01 reduced, 00 lowest
   assign line_cfg_o.dc_term_mode        = r.dct;
   assign line_cfg_o.ac_imp_sel          = r.act;
   assign line_cfg_o.ring_thresh_sel     = r.thr_sel;
   assign line_cfg_o.ringer_imp_synth_en = r.rz;
   assign line_cfg_o.hook_ctrl           = r.hook;
   assign line_cfg_o.hybrid_coef         = r.hyb;
   assign ring_stat_o.ring_pos_flag      = r.pos;
   assign ring_stat_o.ring_neg_flag      = r.neg;
   assign ring_stat_o.ring_oneshot_flag  = r.os_flag;
   assign ring_stat_o.ring_valid         = r.valid;
   assign ring_stat_o.ring_active        = r.active;
   assign sample_tick_o                  = r.tick;
   assign prdata_o                       = r.prdata;
   assign pready_o                       = r.pready;
   assign pslverr_o                      = r.pslverr;
   // Code 00 of dc_term_mode is the lowest voltage mode

endmodule

`default_nettype wire

// ===== tb/rdlc_checker.sv
// Port checker for the ring detector and line configuration block.
// Assumes binding onto rdlc_top with ports of the same names.
`timescale 1ns/1ps
`default_nettype none
module rdlc_checker
   import rdlc_pkg::*;
(
   input wire logic                   core_clk_i,
   input wire logic                   reset_n_i,
   input wire logic                   psel_i,
   input wire logic                   penable_i,
   input wire logic                   pready_o,
   input wire logic                   pslverr_o,
   input wire logic signed [11:0]     ring_sense_p_i,
   input wire logic signed [11:0]     ring_sense_n_i,
   input wire rdlc_pkg::rdlc_line_cfg_t  line_cfg_o,
   input wire rdlc_pkg::rdlc_ring_stat_t ring_stat_o,
   input wire logic                   sample_tick_o
);
   // ****************
   // Properties
   // ****************
   logic signed [12:0] diff;
   logic signed [12:0] thr;
   assign diff = 13'(ring_sense_p_i) - 13'(ring_sense_n_i);
   assign thr = line_cfg_o.ring_thresh_sel ? THR_21V5 : THR_15V0;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_one_wait;
      !pready_o ##1 pready_o;
   endsequence
   a_apb_wait:
   assert property ($rose(penable_i) && psel_i |-> s_one_wait)
      else $error("ready not after one wait");
   a_err_ready:
   assert property (pslverr_o |-> pready_o) else $error("lone error");
   a_dct_reset:
   assert property ($rose(reset_n_i) |-> line_cfg_o.dc_term_mode == 2'h2)
      else $error("dc mode reset");
   a_pos_set:
   assert property (sample_tick_o && diff > thr |=> ring_stat_o[4])
      else $error("pos flag missing");
   a_neg_set:
   assert property (sample_tick_o && diff < -thr |=> ring_stat_o[3])
      else $error("neg flag missing");
   a_none_between:
   assert property (sample_tick_o && diff <= thr && diff >= -thr
      |=> !ring_stat_o[4] && !ring_stat_o[3]) else $error("flag between");
   a_pos_oneshot:
   assert property ($rose(ring_stat_o[4]) |-> ring_stat_o[2])
      else $error("pos without one-shot");
   a_oneshot_cause:
   assert property ($rose(ring_stat_o[2]) |-> ring_stat_o[4] || ring_stat_o[3])
      else $error("one-shot without ring");
   a_flag_hold:
   assert property ($changed(ring_stat_o[4]) |-> $past(sample_tick_o))
      else $error("flag moved off tick");
   a_tick_gap:
   assert property (sample_tick_o |=> !sample_tick_o [*8])
      else $error("ticks too close");
endmodule
bind rdlc_top rdlc_checker u_chk (
   .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .ring_sense_p_i(ring_sense_p_i), .ring_sense_n_i(ring_sense_n_i),
   .line_cfg_o(line_cfg_o), .ring_stat_o(ring_stat_o),
   .sample_tick_o(sample_tick_o));
`default_nettype wire

// ===== tb/rdlc_ring_src.sv
// Line side model: differential ring source on the sense inputs.
// Assumes the bench sets amplitude and half period in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module rdlc_ring_src (
   input  wire logic               clk_i,
   input  wire logic signed [11:0] amp_i,
   input  wire logic [15:0]        half_i,
   output logic signed [11:0]      sense_p_o,
   output logic signed [11:0]      sense_n_o
);
   int                cnt = 0;
   logic              pol = 1'b0;
   logic signed [11:0] p_q = 12'sh000;
   logic signed [11:0] n_q = 12'sh000;
   assign sense_p_o = p_q;
   assign sense_n_o = n_q;
   // Common mode offset on both pins; only sense_p_o carries the ring signal
   always @(posedge clk_i) begin
      cnt <= (half_i != 0 && cnt + 1 >= half_i) ? 0 : cnt + 1;
      if (half_i != 0 && cnt + 1 >= half_i) pol <= ~pol;
      n_q <= 12'sh064;
      p_q <= 12'sh064 + (pol ? -amp_i : amp_i);
   end
endmodule
`default_nettype wire

// ===== tb/rdlc_top_tb.sv
// Self-checking bench for rdlc_top with a register model.
// Assumes CLK_HZ is shortened so one sample is 10 to 22 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module rdlc_top_tb;
   import rdlc_pkg::*;
   localparam int CLK_HZ = 160000;
   localparam int OSL = 16;
   logic core_clk_i, reset_n_i = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, tick, er;
   logic signed [11:0] sp, sn, amp = 0;
   logic [15:0] half = 0;
   rdlc_line_cfg_t cfg;
   rdlc_ring_stat_t st;
   int n_mismatch = 0, comparisons = 0, cyc = 0, regm[int];
   rdlc_top #(.CLK_HZ(CLK_HZ), .ONESHOT_LEN(OSL)) u_dut (.core_clk_i,
      .reset_n_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .ring_sense_p_i(sp),
      .ring_sense_n_i(sn), .line_cfg_o(cfg), .ring_stat_o(st),
      .sample_tick_o(tick));
   rdlc_ring_src u_line (.clk_i(core_clk_i), .amp_i(amp), .half_i(half),
      .sense_p_o(sp), .sense_n_o(sn));
   // ****************
   // Tasks
   // ****************
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w;
      paddr <= {2'h0, a, 2'h0}; pwdata <= {24'h0, d};
      @(posedge core_clk_i);
      penable <= 1'b1;
      // Sampled at the rising edge; a hung slave ends in the cycle limit
      do @(posedge core_clk_i); while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   function automatic int msk(input logic [7:0] a);
      case (a)
         8'h37, 8'h40: return 8'h0F;
         8'h42: return 8'h02;
         8'h48: return 8'hBF;
         8'h70: return 8'h03;
         default: return 8'hFF;
      endcase
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
      regm[a] = d & msk(a);
      repeat (2) @(negedge core_clk_i);
   endtask
   task automatic rdc(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
      `CHK(rd, regm[a])
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge core_clk_i);
         while (tick !== 1'b1) @(negedge core_clk_i);
      end
   endtask
   // ****************
   // Sequence
   // ****************
   initial begin
      core_clk_i = 0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      int unsigned s;
      int d, t, i, k, th;
      logic [7:0] q[$];
      s = $urandom(32'h9EF5D687);
      q = {8'h37, 8'h40, 8'h42, 8'h46, 8'h47, 8'h48, 8'h70};
      for (i = 'h5D; i <= 'h64; i++) q.push_back(i[7:0]);
      foreach (q[i]) regm[q[i]] = 0;
      regm[8'h40] = 8'h08;
      repeat (4) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      @(negedge core_clk_i);
      `CHK(cfg.dc_term_mode, 2'b10)
      foreach (q[i]) rdc(q[i]);
      foreach (q[i]) if (q[i] != 8'h37) wr(q[i], 8'($urandom));
      foreach (q[i]) rdc(q[i]);
      for (i = 0; i < 8; i++) `CHK(cfg.hybrid_coef[8*i +: 8], regm['h5D+i])
      apb(1'b0, 8'h00, 8'hFF);
      `CHK({er, rd}, 33'h100000000)
      for (i = 0; i < 4; i++) begin
         wr(8'h40, {4'h0, i[1:0], ~i[1:0]});
         `CHK(cfg.dc_term_mode, i[1:0])
         `CHK({cfg.ring_thresh_sel, cfg.ringer_imp_synth_en}, {~i[0], ~i[1]})
         wr(8'h70, i[7:0]);
         `CHK(cfg.ac_imp_sel, i[1:0])
      end
      for (k = 0; k < 2; k++) for (i = 0; i < 4; i++) begin
         // Half-wave runs on 15 V, full-wave on 21.5 V
         th = k ? 215 : 150;
         wr(8'h40, {4'h0, 2'b10, 1'b0, k[0]});
         wr(8'h42, {6'h0, k[0], 1'b0});
         d = (i < 2) ? th + 1 + $urandom % 200 : th;
         if (i[0]) d = -d;
         amp <= d[11:0];
         ticks(2);
         @(negedge core_clk_i);
         t = (d > th) || (k == 1 && d < -th);
         `CHK(st[4:2], {d > th, d < -th, t[0]})
         apb(1'b0, 8'h35, 8'h00);
         `CHK(rd, {d > th, d < -th, 2'b0, t[0], 2'b0})
         amp <= 0;
         wr(8'h35, 8'h01);
         ticks(1);
         @(negedge core_clk_i);
         `CHK(st.ring_oneshot_flag, 1'b0)
         `CHK(cfg.hook_ctrl, 1'b1)
         wr(8'h35, 8'h00);
      end
      amp <= 300;
      ticks(2);
      amp <= 0;
      ticks(OSL - 3);
      `CHK(st.ring_oneshot_flag, 1'b1)
      ticks(5);
      `CHK(st.ring_oneshot_flag, 1'b0)
      for (i = 0; i < 10; i++) begin
         wr(8'h37, i[7:0]);
         ticks(2);
         t = 0;
         do begin @(negedge core_clk_i); t++; end while (tick !== 1'b1);
         `CHK(t, CLK_HZ / int'(RATE_TABLE[i]))
      end
      // Valid ring, delay longer than end timeout, validation off
      for (i = 0; i < 3; i++) begin
         wr(8'h46, {i == 1, 7'h01});
         wr(8'h47, 8'h00);
         wr(8'h48, {i != 2, 7'h06});
         amp <= 400;
         half <= 320;
         repeat (12000) @(negedge core_clk_i);
         apb(1'b0, 8'h71, 8'h00);
         `CHK(rd[1:0], (i == 0) ? 2'b11 : 2'b00)
         half <= 0;
         amp <= 0;
         repeat (11000) @(negedge core_clk_i);
         `CHK(st[1:0], {i == 0, 1'b0})
         wr(8'h71, 8'h01);
         apb(1'b0, 8'h71, 8'h00);
         `CHK(rd, 32'h0)
      end
      complete_run();
   end
endmodule
`default_nettype wire
